/* verilog/i2o_queue_port.sv */
// Purpose: inbound and outbound message-queue ports turned into local-bus accesses
// Assumes: target port and local bus run on core_clk; free-list empty flags are same-clock
// Notes: writes are posted through an 8-entry FIFO; a port retries while its write is open
`timescale 1ns/1ps
module i2o_queue_port
  import i2o_pkg::*;
(
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // target access port
  input wire logic pci_req,
  input wire logic pci_wr,
  input wire logic [OFS_W-1:0] pci_ofs,
  input wire logic [DATA_W-1:0] pci_wdata,
  output logic pci_ack,
  output logic pci_retry,
  output logic [DATA_W-1:0] pci_rdata,
  // local-bus memory master
  output logic lb_req,
  output logic lb_we,
  output logic [DATA_W-1:0] lb_addr,
  output logic [DATA_W-1:0] lb_wdata,
  input wire logic lb_ack,
  input wire logic [DATA_W-1:0] lb_rdata,
  // list status
  input wire logic out_free_empty,
  input wire logic in_free_empty,
  input wire logic outbound_post_taken,
  output logic outbound_post_service_request
);
  lb_state_e state_ff;
  logic [DATA_W-1:0] ptr_ff [4];
  logic [1:0] busy_ff;
  logic rd_dir_ff;
  logic wr_dir_ff;
  logic ack_ff;
  logic retry_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic req_ff;
  logic we_ff;
  logic [DATA_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [CNT_W-1:0] post_cnt_ff;
  logic svc_ff;

  fifo_if #(.W(ENTRY_W)) push_if ();
  fifo_if #(.W(ENTRY_W)) pop_if ();

  msg_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) post_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .wr(push_if.snk),
    .rd(pop_if.src)
  );

  // decode of the current request
  // a request whose fetch is already in flight must not be answered twice
  wire idle_ans = pci_req && !ack_ff && !retry_ff && state_ff != LB_READ;
  wire hit = port_hit(pci_ofs);
  wire dir = port_dir(pci_ofs);
  wire port_busy = busy_ff[dir];
  wire free_empty = dir ? in_free_empty : out_free_empty;
  wire take_wr = idle_ans && hit && pci_wr && !port_busy && push_if.ready;
  wire give_ones = idle_ans && hit && !pci_wr && !port_busy && free_empty;
  // reads wait behind posted writes so message order holds
  wire start_rd = idle_ans && hit && !pci_wr && !port_busy && !free_empty
    && state_ff == LB_IDLE && !pop_if.valid;
  wire do_retry = idle_ans && hit && port_busy;
  wire unmapped = idle_ans && !hit;
  wire start_wr = state_ff == LB_IDLE && pop_if.valid;
  wire wr_done = state_ff == LB_WRITE && lb_ack;
  wire rd_done = state_ff == LB_READ && lb_ack;
  wire head_dir = pop_if.data[DATA_W];
  wire post_inc = wr_done && wr_dir_ff == DIR_OUT;
  wire [CNT_W-1:0] nxt_post_cnt = post_cnt_ff + (post_inc ? CNT_ONE : '0)
    - ((outbound_post_taken && post_cnt_ff != '0) ? CNT_ONE : '0);
  wire [1:0] start_ptr = head_dir ? 2'(PTR_IN_POST) : 2'(PTR_OUT_POST);
  wire [1:0] free_ptr = dir ? 2'(PTR_IN_FREE) : 2'(PTR_OUT_FREE);
  wire [1:0] done_ptr = (state_ff == LB_WRITE) ? {1'b0, wr_dir_ff} : {1'b1, rd_dir_ff};

  assign push_if.data = {dir, pci_wdata};
  assign push_if.valid = take_wr;
  assign pop_if.ready = wr_done;

  // local-bus sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= LB_IDLE;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= PORT_RESET;
      wdata_ff <= PORT_RESET;
      wr_dir_ff <= 1'b0;
      rd_dir_ff <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        LB_IDLE: begin
          if (start_wr) begin
            state_ff <= LB_WRITE;
            req_ff <= 1'b1;
            we_ff <= 1'b1;
            addr_ff <= ptr_ff[start_ptr];
            wdata_ff <= pop_if.data[DATA_W-1:0];
            wr_dir_ff <= head_dir;
          end else if (start_rd) begin
            state_ff <= LB_READ;
            req_ff <= 1'b1;
            we_ff <= 1'b0;
            addr_ff <= ptr_ff[free_ptr];
            rd_dir_ff <= dir;
          end
        end
        LB_WRITE, LB_READ: begin
          if (lb_ack) begin
            state_ff <= LB_IDLE;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
          end
        end
        default: state_ff <= LB_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_ff[PTR_OUT_POST] <= OUT_POST_BASE;
      ptr_ff[PTR_IN_POST] <= IN_POST_BASE;
      ptr_ff[PTR_OUT_FREE] <= OUT_FREE_BASE;
      ptr_ff[PTR_IN_FREE] <= IN_FREE_BASE;
    end else if (ce && (wr_done || rd_done)) begin
      ptr_ff[done_ptr] <= ptr_ff[done_ptr] + ENTRY_BYTES;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 2'b00;
    end else if (ce) begin
      if (wr_done) busy_ff[wr_dir_ff] <= 1'b0;
      if (take_wr) busy_ff[dir] <= 1'b1;
    end
  end

  // answers to the target port; one-cycle pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      retry_ff <= 1'b0;
      rdata_ff <= PORT_RESET;
    end else if (ce) begin
      ack_ff <= take_wr || give_ones || unmapped || rd_done;
      retry_ff <= do_retry;
      if (give_ones) rdata_ff <= EMPTY_WORD;
      else if (rd_done) rdata_ff <= lb_rdata;
      else if (unmapped) rdata_ff <= PORT_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      post_cnt_ff <= '0;
      svc_ff <= 1'b0;
    end else if (ce) begin
      post_cnt_ff <= nxt_post_cnt;
      svc_ff <= (nxt_post_cnt != '0);
    end
  end

  assign pci_ack = ack_ff;
  assign pci_retry = retry_ff;
  assign pci_rdata = rdata_ff;
  assign lb_req = req_ff;
  assign lb_we = we_ff;
  assign lb_addr = addr_ff;
  assign lb_wdata = wdata_ff;
  assign outbound_post_service_request = svc_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  in_write_addr_a: assert property (ce && start_wr && head_dir |=>
    lb_req && lb_we && lb_addr == $past(ptr_ff[PTR_IN_POST]))
    else $error("inbound post write address wrong");
  in_retry_a: assert property (ce && take_wr && dir |=> busy_ff[DIR_IN]
    until_with (wr_done && wr_dir_ff))
    else $error("inbound port not held busy");
  busy_retry_a: assert property (ce && do_retry |=> pci_retry && !pci_ack)
    else $error("busy port access not retried");
  in_read_a: assert property (ce && start_rd && dir |=>
    lb_req && !lb_we && lb_addr == $past(ptr_ff[PTR_IN_FREE]))
    else $error("inbound free read address wrong");
  empty_ones_a: assert property (ce && give_ones |=>
    pci_ack && pci_rdata == EMPTY_WORD && !(lb_req && !lb_we))
    else $error("empty free list not all ones");
  out_write_addr_a: assert property (ce && start_wr && !head_dir |=>
    lb_addr == $past(ptr_ff[PTR_OUT_POST]) && lb_wdata == $past(pop_if.data[DATA_W-1:0]))
    else $error("outbound post write wrong");
  read_data_a: assert property (ce && rd_done |=>
    pci_ack && pci_rdata == $past(lb_rdata))
    else $error("free list data not returned");
  service_req_a: assert property (ce && post_inc |=>
    outbound_post_service_request)
    else $error("service request not raised after outbound post");
  ptr_step_a: assert property (ce && wr_done |=>
    ptr_ff[$past(done_ptr)] == $past(ptr_ff[done_ptr]) + ENTRY_BYTES)
    else $error("pointer did not advance one entry");

  write_seen_c: cover property (ce && take_wr ##[1:20] wr_done);
  fetch_seen_c: cover property (ce && start_rd ##[1:20] rd_done);
  retry_seen_c: cover property (ce && do_retry);
endmodule // i2o_queue_port

/* pkg/i2o_pkg.sv */
// Purpose: shared constants and types for the message-queue port block
// Assumes: port offsets are byte offsets on the target access port
// Notes: base pointer values are plain defaults, not hardware figures
package i2o_pkg;
  localparam int OFS_W = 8;
  localparam int DATA_W = 32;
  localparam int ENTRY_W = DATA_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int CNT_W = 16;
  localparam logic [OFS_W-1:0] OUTBOUND_PORT_OFS = 8'h00;
  localparam logic [OFS_W-1:0] INBOUND_PORT_OFS = 8'h40;
  localparam logic [DATA_W-1:0] EMPTY_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] PORT_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] ENTRY_BYTES = 32'h00000004;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // pointer slots and direction bits
  localparam int DIR_OUT = 0;
  localparam int DIR_IN = 1;
  localparam int PTR_OUT_POST = 0;
  localparam int PTR_IN_POST = 1;
  localparam int PTR_OUT_FREE = 2;
  localparam int PTR_IN_FREE = 3;
  localparam logic [DATA_W-1:0] OUT_POST_BASE = 32'h00001000;
  localparam logic [DATA_W-1:0] IN_POST_BASE = 32'h00002000;
  localparam logic [DATA_W-1:0] OUT_FREE_BASE = 32'h00003000;
  localparam logic [DATA_W-1:0] IN_FREE_BASE = 32'h00004000;

  typedef enum logic [1:0] {
    LB_IDLE = 2'b00,
    LB_WRITE = 2'b01,
    LB_READ = 2'b10
  } lb_state_e;

  // 1 when the offset names one of the two queue ports
  function automatic logic port_hit(input logic [OFS_W-1:0] ofs);
    port_hit = (ofs == OUTBOUND_PORT_OFS) || (ofs == INBOUND_PORT_OFS);
  endfunction

  // direction bit of a port offset
  function automatic logic port_dir(input logic [OFS_W-1:0] ofs);
    port_dir = (ofs == INBOUND_PORT_OFS);
  endfunction
endpackage

/* pkg/fifo_if.sv */
// Purpose: valid/ready carrier between the queue block and its FIFO
// Assumes: one producer and one consumer on the same clock
// Notes: data is taken when valid and ready are both high
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 33);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* verilog/msg_fifo.sv */
// Purpose: small flip-flop FIFO holding posted port writes
// Assumes: width and depth are parameters, depth a power of two
// Notes: ready drops when full, valid drops when empty
`timescale 1ns/1ps
module msg_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // filling and draining sides
  fifo_if.snk wr,
  fifo_if.src rd
);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;

  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data = mem_ff[rp_ff];

  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_ff[wp_ff] <= wr.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop) rp_ff <= rp_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end

  fifo_count_a: assert property (@(posedge core_clk) disable iff (rst)
    cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // msg_fifo

/* tb/lb_mem.sv */
// Purpose: local-bus memory model facing the queue-port block
// Assumes: one request at a time, held until acknowledged
// Notes: read word mixes the address; idle data flips every cycle
`timescale 1ns/1ps
module lb_mem
  import i2o_pkg::*;
#(
  parameter int LAT = 4
) (
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  // local-bus slave
  input wire logic lb_req,
  input wire logic lb_we,
  input wire logic [DATA_W-1:0] lb_addr,
  input wire logic [DATA_W-1:0] lb_wdata,
  output logic lb_ack,
  output logic [DATA_W-1:0] lb_rdata,
  // last write seen and count of writes
  output logic [DATA_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output int wr_cnt
);
  localparam logic [DATA_W-1:0] RD_MIX = 32'h5A5A5A5A;
  int wait_ff;
  wire logic hit = lb_req && !lb_ack && (wait_ff == LAT - 1);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_ff <= 0;
      lb_ack <= 1'b0;
      lb_rdata <= 32'h0;
      wr_cnt <= 0;
    end else if (hit) begin
      wait_ff <= 0;
      lb_ack <= 1'b1;
      lb_rdata <= lb_we ? ~lb_rdata : (lb_addr ^ RD_MIX);
      wr_addr <= lb_we ? lb_addr : wr_addr;
      wr_data <= lb_we ? lb_wdata : wr_data;
      wr_cnt <= wr_cnt + (lb_we ? 1 : 0);
    end else begin
      // slow answer: count while the request stands
      wait_ff <= (lb_req && !lb_ack) ? wait_ff + 1 : 0;
      lb_ack <= 1'b0;
      lb_rdata <= ~lb_rdata;
    end
  end
endmodule // lb_mem

/* tb/i2o_message_queue_port_bench.sv */
// Purpose: self-checking bench for the queue-port block
// Assumes: memory answers each local-bus request after LAT cycles
// Notes: inputs move on falling edges; ce stays high
`timescale 1ns/1ps
module i2o_message_queue_port_bench;
  import i2o_pkg::*;
  typedef struct packed {
    logic wr;
    logic [OFS_W-1:0] ofs;
    logic empty;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] addr;
  } row_s;
  localparam logic [DATA_W-1:0] RD_MIX = 32'h5A5A5A5A;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pci_req = 1'b0;
  logic pci_wr = 1'b0;
  logic [OFS_W-1:0] pci_ofs = 8'h00;
  logic [DATA_W-1:0] pci_wdata = 32'h0;
  logic in_empty = 1'b1;
  logic out_empty = 1'b1;
  logic taken = 1'b0;
  logic pci_ack, pci_retry, lb_req, lb_we, lb_ack, srv, rty;
  logic [DATA_W-1:0] pci_rdata, lb_addr, lb_wdata, lb_rdata, wr_addr, wr_data, rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wr_cnt, old;
  row_s rows [9];
  always #20 core_clk = ~core_clk;
  i2o_queue_port dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1), .pci_req(pci_req),
    .pci_wr(pci_wr), .pci_ofs(pci_ofs), .pci_wdata(pci_wdata), .pci_ack(pci_ack),
    .pci_retry(pci_retry), .pci_rdata(pci_rdata), .lb_req(lb_req), .lb_we(lb_we),
    .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
    .out_free_empty(out_empty), .in_free_empty(in_empty), .outbound_post_taken(taken),
    .outbound_post_service_request(srv));
  lb_mem #(.LAT(4)) mem_u (.core_clk(core_clk), .rst(rst), .lb_req(lb_req), .lb_we(lb_we),
    .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one access; a clock passes before the request rises again
  task automatic acc(input logic w, input logic [OFS_W-1:0] o, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    pci_req = 1'b1;
    pci_wr = w;
    pci_ofs = o;
    pci_wdata = d;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pci_ack !== 1'b1 && pci_retry !== 1'b1 && n < 60);
    if (n >= 60)
      n_mismatch++;
    rty = pci_retry;
    rd = pci_rdata;
    @(negedge core_clk);
    pci_req = 1'b0;
  endtask
  task automatic host(input logic w, input logic [OFS_W-1:0] o, input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    do begin
      acc(w, o, d);
      k++;
    end while (rty === 1'b1 && k < 20);
    if (rty === 1'b1)
      n_mismatch++;
  endtask
  task automatic wait_wr();
    int n;
    n = 0;
    while (wr_cnt == old && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    if (wr_cnt == old)
      n_mismatch++;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    rows[0] = '{1'b1, INBOUND_PORT_OFS, 1'b1, 32'h11111111, IN_POST_BASE};
    rows[1] = '{1'b1, OUTBOUND_PORT_OFS, 1'b1, 32'h22222222, OUT_POST_BASE};
    rows[2] = '{1'b0, INBOUND_PORT_OFS, 1'b1, EMPTY_WORD, 32'h0};
    rows[3] = '{1'b0, OUTBOUND_PORT_OFS, 1'b1, EMPTY_WORD, 32'h0};
    rows[4] = '{1'b0, OUTBOUND_PORT_OFS, 1'b0, OUT_FREE_BASE ^ RD_MIX, 32'h0};
    rows[5] = '{1'b0, INBOUND_PORT_OFS, 1'b0, IN_FREE_BASE ^ RD_MIX, 32'h0};
    rows[6] = '{1'b0, 8'h20, 1'b1, 32'h0, 32'h0};
    rows[7] = '{1'b1, INBOUND_PORT_OFS, 1'b1, 32'h33333333, IN_POST_BASE + ENTRY_BYTES};
    rows[8] = '{1'b0, OUTBOUND_PORT_OFS, 1'b0, (OUT_FREE_BASE + ENTRY_BYTES) ^ RD_MIX, 32'h0};
    repeat (10) @(negedge core_clk);
    chk({29'h0, pci_ack, lb_req, srv}, 32'h0); // reset state
    rst = 1'b0;
    foreach (rows[i]) begin
      old = wr_cnt;
      in_empty = rows[i].empty;
      out_empty = rows[i].empty;
      host(rows[i].wr, rows[i].ofs, rows[i].data);
      if (rows[i].wr) begin
        wait_wr();
        chk(wr_addr, rows[i].addr);
        chk(wr_data, rows[i].data);
      end else
        chk(rd, rows[i].data);
    end
    $display("table rows done");
    chk({31'h0, srv}, 32'h1);
    taken = 1'b1;
    @(negedge core_clk);
    taken = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({31'h0, srv}, 32'h0);
    $display("service request done");
    in_empty = 1'b1;
    out_empty = 1'b1;
    old = wr_cnt;
    acc(1'b1, INBOUND_PORT_OFS, 32'h44444444);
    acc(1'b0, INBOUND_PORT_OFS, 32'h0);
    chk({31'h0, rty}, 32'h1);
    wait_wr();
    chk(wr_addr, IN_POST_BASE + 32'h8);
    old = wr_cnt;
    acc(1'b1, OUTBOUND_PORT_OFS, 32'h55555555);
    acc(1'b1, OUTBOUND_PORT_OFS, 32'h66666666);
    chk({31'h0, rty}, 32'h1);
    wait_wr();
    chk(wr_data, 32'h55555555);
    chk(wr_addr, OUT_POST_BASE + ENTRY_BYTES);
    $display("retry cases done");
    // mid-run reset brings pointers back to their bases
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    chk({29'h0, pci_ack, lb_req, srv}, 32'h0); // reset state
    rst = 1'b0;
    old = wr_cnt;
    host(1'b1, INBOUND_PORT_OFS, 32'h77777777);
    wait_wr();
    chk(wr_addr, IN_POST_BASE);
    $display("reset case done");
    end_sim();
  end
endmodule // i2o_message_queue_port_bench
